// ### src/sesr_pkg.sv
package sesr_pkg;

    // ------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ENABLE  = 8'h06;
    localparam logic [7:0] OP_DISABLE = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD  = 8'h03;
    localparam logic [7:0] OP_ARR_WR  = 8'h02;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT  = 1;
    localparam int ST_BGLO_BIT = 2;
    localparam int ST_BGHI_BIT = 3;
    localparam int ST_LOCK_BIT = 7;

    // ------------------------------------------------------------
    // array geometry and guarded regions
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 13;
    localparam int         ARR_DEPTH    = 8192;
    localparam logic [12:0] QUARTER_BASE = 13'h1800;
    localparam logic [12:0] HALF_BASE    = 13'h1000;
    localparam logic [12:0] ADDR_ONE     = 13'h0001;

    // ------------------------------------------------------------
    // frame bit counts
    // ------------------------------------------------------------
    localparam logic [4:0] BITS_CMD  = 5'h08;
    localparam logic [4:0] BITS_STATUS_UPDATE_CMD = 5'h10;
    localparam logic [4:0] BITS_AHI  = 5'h10;
    localparam logic [4:0] BITS_MAX  = 5'h1F;
    localparam logic [4:0] BITS_ONE  = 5'h01;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TW_US         = 5000;
    localparam int TW_CYCLES_DEF = (TW_US * 1000) / CLK_PERIOD_NS;
    localparam int TW_CNT_W      = 20;
    localparam logic [TW_CNT_W-1:0] TW_ONE = 20'h00001;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        L_CMD  = 3'b000,
        L_ADDR = 3'b001,
        L_READ = 3'b010,
        L_STAT = 3'b011,
        L_HOLD = 3'b100,
        L_DROP = 3'b101
    } sesr_lnk_st_t;

    typedef struct packed {
        sesr_lnk_st_t st;
        logic [4:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   op;
        logic [12:0]  addr;
        logic [7:0]   obyte;
        logic [7:0]   stat_m;
        logic [7:0]   stat_s;
    } sesr_lnk_t;

    typedef struct packed {
        logic                cs_m;
        logic                cs_s;
        logic                cs_d;
        logic                wp_m;
        logic                wp_s;
        logic                armed;
        logic                busy;
        logic                modify_permit_latch;
        logic                pend;
        logic                lock;
        logic                new_lock;
        logic [1:0]          bg;
        logic [1:0]          new_bg;
        logic [TW_CNT_W-1:0] tw_cnt;
        logic                aw_taken;
        logic                aw_refused;
    } sesr_sys_t;

    // nonvolatile bits start in their delivery state (all clear)
    localparam sesr_sys_t SYS_RESET = '0;

endpackage : sesr_pkg

// ### src/sesr_core.sv
// Function
// - disable-writes clears permit latch at deselect
// - permit latch cleared by reset and completions
// - status read always accepted, repeats while clocked
// - busy high only during self-timed cycles
// - no permit latch, no write accepted
// - guard bits nonvolatile, refuse guarded array writes
// - lock and low protect pin block status writes
// - status write needs prior enable-writes
// - status write exactly opcode plus one byte
// - status write starts timed cycle, latch clears at its end
// - new guard and lock bits visible after cycle
// - other status bits untouched, b6-b4 read zero
// - lock clear permits status writes always
// - lock set, protect pin high still permits
// - hard lock whenever lock set and pin low
// - hard lock ends only with pin high or reset
// - array read loads address then streams data
// - read address advances after every byte
// - read address wraps past the top
// - deselect ends array read at any bit
// - array read refused while busy
// - one-byte opcodes as defined
// - unknown opcode deselects for the frame
// - only enable-writes sets the permit latch
`timescale 1ns/1ps
`default_nettype none

module sesr_core
    import sesr_pkg::*;
#(
    parameter int unsigned TW_CYCLES = TW_CYCLES_DEF
) (
    input  wire logic        clock_in,          // system clock
    input  wire logic        rst_n_in,          // sync reset, low
    input  wire logic        spi_clk_in,        // link clock
    input  wire logic        spi_cs_n_in,       // chip select, low
    input  wire logic        spi_mosi_in,       // serial data in
    output logic             spi_miso_out,      // serial data out
    output logic             spi_miso_oe_n_out, // low while driving
    input  wire logic        wp_n_in,           // write protect pin
    input  wire logic        aw_req_in,         // array write request
    input  wire logic [12:0] aw_addr_in,        // array write address
    input  wire logic [7:0]  aw_data_in,        // array write data
    output logic             aw_taken_out,      // write accepted
    output logic             aw_refused_out,    // write refused
    output logic [7:0]       status_out         // status byte
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] sesr_status(input sesr_sys_t v);
        logic [7:0] b;
        b = 8'h00;
        b[ST_BUSY_BIT] = v.busy;
        b[ST_WEL_BIT]  = v.modify_permit_latch;
        b[ST_BGLO_BIT] = v.bg[0];
        b[ST_BGHI_BIT] = v.bg[1];
        b[ST_LOCK_BIT] = v.lock;
        return b;
    endfunction : sesr_status

    function automatic logic sesr_guarded(input logic [12:0] a,
                                          input logic [1:0]  g);
        case (g)
            2'h0:    return 1'b0;
            2'h1:    return a >= QUARTER_BASE;
            2'h2:    return a >= HALF_BASE;
            default: return 1'b1;
        endcase
    endfunction : sesr_guarded

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sesr_lnk_t    lnk;
    sesr_lnk_t    next_lnk;
    sesr_sys_t    sys;
    sesr_sys_t    next_sys;
    logic         first;
    logic [4:0]   cnt0;
    sesr_lnk_st_t st0;
    logic [7:0]   sh0;
    logic [7:0]   byte_in;
    logic         done;
    logic         rd_step;
    logic         miso_q;
    logic         oe_n_q;
    logic [7:0]   stat_cur;
    logic         rise;
    logic         hard;
    logic         is_en;
    logic         is_dis;
    logic         is_status_update_cmd;
    logic         status_update_cmd_go;
    logic         aw_go;
    logic [7:0]   mem [0:ARR_DEPTH-1];

    assign stat_cur = sesr_status(sys);

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    // frame start marker: set while deselected, cleared by first edge
    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    always_comb begin
        next_lnk = lnk;
        rd_step  = 1'b0;
        // bits are independent flags, so per-bit sync is enough
        next_lnk.stat_m = stat_cur;
        next_lnk.stat_s = lnk.stat_m;
        cnt0 = first ? 5'h00 : lnk.cnt;
        st0  = first ? L_CMD : lnk.st;
        sh0  = first ? 8'h00 : lnk.sh;
        // saturate only while waiting for deselect, so an overlong
        // command never aliases to a valid length; data phases wrap
        next_lnk.cnt = (cnt0 == BITS_MAX && st0 == L_HOLD) ?
                       cnt0 : cnt0 + BITS_ONE;
        byte_in        = {sh0[6:0], spi_mosi_in};
        next_lnk.sh    = byte_in;
        next_lnk.st    = st0;
        next_lnk.obyte = {lnk.obyte[6:0], 1'b0};
        done = (next_lnk.cnt[2:0] == 3'h0);
        case (st0)
            L_CMD: begin
                if (done) begin
                    next_lnk.op = byte_in;
                    case (byte_in)
                        OP_ARR_RD: begin
                            next_lnk.st = lnk.stat_s[ST_BUSY_BIT] ?
                                          L_DROP : L_ADDR;
                        end
                        OP_STAT_RD: begin
                            next_lnk.st    = L_STAT;
                            next_lnk.obyte = lnk.stat_s;
                        end
                        OP_ENABLE, OP_DISABLE, OP_STAT_WR,
                        OP_ARR_WR: begin
                            next_lnk.st = L_HOLD;
                        end
                        default: begin
                            next_lnk.st = L_DROP;
                        end
                    endcase
                end
            end
            L_ADDR: begin
                if (done) begin
                    if (next_lnk.cnt == BITS_AHI) begin
                        next_lnk.addr[12:8] = byte_in[4:0];
                    end else begin
                        next_lnk.obyte = mem[{lnk.addr[12:8], byte_in}];
                        next_lnk.addr  = {lnk.addr[12:8], byte_in}
                                         + ADDR_ONE;
                        next_lnk.st    = L_READ;
                    end
                end
            end
            L_READ: begin
                if (done) begin
                    rd_step        = 1'b1;
                    next_lnk.obyte = mem[lnk.addr];
                    next_lnk.addr  = lnk.addr + ADDR_ONE;
                end
            end
            L_STAT: begin
                if (done) begin
                    next_lnk.obyte = lnk.stat_s;
                end
            end
            default: begin
            end
        endcase
    end

    // no reset here: the frame marker restarts the frame logic and
    // the clock only runs inside frames
    always_ff @(posedge spi_clk_in) begin
        lnk <= next_lnk;
    end

    always_ff @(negedge spi_clk_in) begin
        miso_q <= lnk.obyte[7];
        oe_n_q <= !((lnk.st == L_READ) || (lnk.st == L_STAT));
    end

    assign spi_miso_out = miso_q;
    // deselect releases the output at once
    // the output flop still holds the last frame until the first falling edge
    assign spi_miso_oe_n_out = oe_n_q | spi_cs_n_in | first;

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    // frame fields are read only after deselect, while link clock idles
    assign rise    = sys.cs_s & ~sys.cs_d & sys.armed;
    assign hard    = sys.lock & ~sys.wp_s;
    assign is_en   = rise && lnk.st == L_HOLD && lnk.op == OP_ENABLE
                     && lnk.cnt == BITS_CMD;
    assign is_dis  = rise && lnk.st == L_HOLD && lnk.op == OP_DISABLE
                     && lnk.cnt == BITS_CMD;
    assign is_status_update_cmd = rise && lnk.st == L_HOLD && lnk.op == OP_STAT_WR
                     && lnk.cnt == BITS_STATUS_UPDATE_CMD;
    assign status_update_cmd_go = is_status_update_cmd && sys.modify_permit_latch && !sys.busy && !hard;

    always_comb begin
        next_sys            = sys;
        aw_go               = 1'b0;
        next_sys.cs_m       = spi_cs_n_in;
        next_sys.cs_s       = sys.cs_m;
        next_sys.cs_d       = sys.cs_s;
        next_sys.wp_m       = wp_n_in;
        next_sys.wp_s       = sys.wp_m;
        next_sys.aw_taken   = 1'b0;
        next_sys.aw_refused = 1'b0;
        // selection only after a falling select edge since reset
        if (!sys.cs_s && sys.cs_d) begin
            next_sys.armed = 1'b1;
        end
        if (sys.busy) begin
            if (sys.tw_cnt == TW_ONE) begin
                next_sys.busy = 1'b0;
                next_sys.modify_permit_latch  = 1'b0;
                next_sys.pend = 1'b0;
                if (sys.pend) begin
                    // only lock and guard bits change
                    next_sys.bg   = sys.new_bg;
                    next_sys.lock = sys.new_lock;
                end
            end else begin
                next_sys.tw_cnt = sys.tw_cnt - TW_ONE;
            end
        end
        // commands after the timer so a set in the same cycle wins
        if (is_en) begin
            next_sys.modify_permit_latch = 1'b1;
        end
        if (is_dis) begin
            next_sys.modify_permit_latch = 1'b0;
        end
        if (status_update_cmd_go) begin
            next_sys.busy     = 1'b1;
            next_sys.pend     = 1'b1;
            next_sys.tw_cnt   = TW_CNT_W'(TW_CYCLES);
            next_sys.new_bg   = {lnk.sh[ST_BGHI_BIT], lnk.sh[ST_BGLO_BIT]};
            next_sys.new_lock = lnk.sh[ST_LOCK_BIT];
        end
        if (aw_req_in) begin
            // guarded region refuses
            // latch must stand before the request and not be ending now
            if (sys.modify_permit_latch && next_sys.modify_permit_latch && !next_sys.busy
                && !sesr_guarded(aw_addr_in, sys.bg)) begin
                aw_go             = 1'b1;
                next_sys.busy     = 1'b1;
                next_sys.pend     = 1'b0;
                next_sys.tw_cnt   = TW_CNT_W'(TW_CYCLES);
                next_sys.aw_taken = 1'b1;
            end else begin
                next_sys.aw_refused = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sys <= SYS_RESET;
        end else begin
            sys <= next_sys;
        end
    end

    always_ff @(posedge clock_in) begin
        if (aw_go) begin
            mem[aw_addr_in] <= aw_data_in;
        end
    end

    assign aw_taken_out   = sys.aw_taken;
    assign aw_refused_out = sys.aw_refused;
    assign status_out     = stat_cur;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_DISABLE_WRITES_CMD_CLR: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) is_dis && !is_en |=> !sys.modify_permit_latch)
        else $error("latch not cleared by disable-writes");

    AST_WEL_SRC: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) $rose(sys.modify_permit_latch) |-> $past(is_en))
        else $error("latch set without enable-writes");

    AST_STATUS_UPDATE_CMD_WEL: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) $rose(sys.busy) |-> $past(sys.modify_permit_latch))
        else $error("write cycle started without latch");

    AST_HARD_REJ: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) is_status_update_cmd && hard |=> !sys.pend
        || $past(sys.pend))
        else $error("status write taken in hard lock");

    AST_TW_LOAD: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        $rose(sys.busy) |-> sys.tw_cnt == TW_CNT_W'(TW_CYCLES))
        else $error("timed cycle length wrong");

    AST_TW_END: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        sys.busy && sys.tw_cnt == TW_ONE && !is_en && !aw_req_in
        |=> !sys.busy && !sys.modify_permit_latch)
        else $error("cycle end did not clear busy and latch");

    AST_NV_CHG: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) $changed({sys.lock, sys.bg})
        |-> $past(sys.busy) && $past(sys.pend) && !sys.busy)
        else $error("guard or lock bits changed early");

    AST_GUARD: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) sys.aw_taken
        |-> !sesr_guarded($past(aw_addr_in), $past(sys.bg)))
        else $error("write taken in guarded region");

    AST_RSV: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) status_out[6:4] == 3'h0)
        else $error("reserved status bits not zero");

    AST_RD_INC: assert property (@(posedge spi_clk_in)
        disable iff (spi_cs_n_in)
        rd_step |=> lnk.addr == $past(lnk.addr) + ADDR_ONE)
        else $error("read address did not advance");

    CV_STATUS_UPDATE_CMD: cover property (@(posedge clock_in)
        disable iff (!rst_n_in) status_update_cmd_go ##1 sys.busy[*3]);

    CV_AW: cover property (@(posedge clock_in)
        disable iff (!rst_n_in) sys.aw_taken);

    CV_READ: cover property (@(posedge spi_clk_in)
        disable iff (spi_cs_n_in) rd_step ##8 rd_step);

endmodule : sesr_core

`default_nettype wire

// ### bench/sesr_host.sv
`timescale 1ns/1ps
`default_nettype none

module sesr_host
    import sesr_pkg::*;
(
    output logic      spi_clk_out,  // link clock, still between frames
    output logic      spi_cs_n_out, // chip select, low
    output logic      spi_mosi_out, // serial data to device
    input  wire logic spi_miso_in   // resolved device output
);
    initial begin
        spi_clk_out  = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end

    task automatic open_frame();
        spi_cs_n_out = 1'b0;
        // select must stay low long enough for the system clock to see it
        #250;
    endtask : open_frame

    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi_out = tx[i];
            // clock idles low between frames, two toggles per bit
            #3 spi_clk_out = ~spi_clk_out;
            rx[i] = spi_miso_in;
            #3 spi_clk_out = ~spi_clk_out;
        end
    endtask : xfer_byte

    task automatic close_frame();
        spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        #500;
    endtask : close_frame

    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        open_frame();
        xfer_byte(op, rx);
        close_frame();
    endtask : cmd

    task automatic stat_wr(input logic [7:0] d);
        logic [7:0] rx;
        open_frame();
        xfer_byte(OP_STAT_WR, rx);
        xfer_byte(d, rx);
        close_frame();
    endtask : stat_wr

    task automatic poll_idle(output logic ok);
        logic [7:0] st;
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            open_frame();
            xfer_byte(OP_STAT_RD, st);
            xfer_byte(8'h00, st);
            close_frame();
            ok = (st[ST_BUSY_BIT] === 1'b0);
        end
    endtask : poll_idle
endmodule : sesr_host

`default_nettype wire

// ### bench/spi_eeprom_status_and_read_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_status_and_read_tb
    import sesr_pkg::*;
;
    logic        clock_in;
    logic        rst_n_in;
    logic        wp_n;
    logic        aw_req;
    logic [12:0] aw_addr;
    logic [7:0]  aw_data;
    logic        aw_taken;
    logic        aw_refused;
    logic [7:0]  status;
    logic        miso;
    logic        oe_n;
    logic        spi_clk;
    logic        cs_n;
    logic        mosi;
    wire         miso_w;
    int          failures;
    int          tests_run;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic        ok;

    // undriven line shows the inverse of the host's data
    assign miso_w = oe_n ? ~mosi : miso;

    sesr_core #(.TW_CYCLES(20)) u_dut (
        .clock_in         (clock_in),
        .rst_n_in         (rst_n_in),
        .spi_clk_in       (spi_clk),
        .spi_cs_n_in      (cs_n),
        .spi_mosi_in      (mosi),
        .spi_miso_out     (miso),
        .spi_miso_oe_n_out(oe_n),
        .wp_n_in          (wp_n),
        .aw_req_in        (aw_req),
        .aw_addr_in       (aw_addr),
        .aw_data_in       (aw_data),
        .aw_taken_out     (aw_taken),
        .aw_refused_out   (aw_refused),
        .status_out       (status)
    );

    sesr_host u_host (
        .spi_clk_out (spi_clk),
        .spi_cs_n_out(cs_n),
        .spi_mosi_out(mosi),
        .spi_miso_in (miso_w)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
            failures++;
        end
    endtask : check

    task automatic test_done();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic settle();
        repeat (6) @(negedge clock_in);
    endtask : settle

    // taken in bit 1, refused in bit 0
    task automatic aw(input logic [12:0] a, input logic [7:0] d,
                      output logic [7:0] res);
        logic tk;
        logic rf;
        tk = 1'b0;
        rf = 1'b0;
        @(negedge clock_in);
        aw_req = 1'b1;
        aw_addr = a;
        aw_data = d;
        @(negedge clock_in);
        // the answer pulse stands from the edge that took the request
        tk = aw_taken;
        rf = aw_refused;
        aw_req = 1'b0;
        repeat (3) begin
            @(posedge clock_in);
            #1;
            tk = tk | aw_taken;
            rf = rf | aw_refused;
        end
        res = {6'h00, tk, rf};
    endtask : aw

    task automatic rd2(input logic [7:0] op, input logic [12:0] a,
                       output logic [7:0] r0, output logic [7:0] r1);
        logic [7:0] rx;
        u_host.open_frame();
        u_host.xfer_byte(op, rx);
        if (op == OP_ARR_RD) begin
            u_host.xfer_byte({3'h0, a[12:8]}, rx);
            u_host.xfer_byte(a[7:0], rx);
        end
        u_host.xfer_byte(8'h00, r0);
        u_host.xfer_byte(8'h00, r1);
        u_host.close_frame();
    endtask : rd2

    task automatic set_wp(input logic v);
        @(negedge clock_in);
        wp_n = v;
        settle();
    endtask : set_wp

    task automatic idle();
        u_host.poll_idle(ok);
        check("idle", {7'h00, ok}, 8'h01);
    endtask : idle

    initial begin
        #400000;
        failures++;
        test_done();
    end

    initial begin
        failures = 0;
        tests_run = 0;
        rst_n_in = 1'b0;
        wp_n = 1'b1;
        aw_req = 1'b0;
        aw_addr = 13'h0000;
        aw_data = 8'h00;
        repeat (5) @(negedge clock_in);
        rst_n_in = 1'b1;
        settle();
        check("rst", status, 8'h00);
        rd2(OP_STAT_RD, 13'h0000, b0, b1);
        check("status_read_cmd", b1, 8'h00);
        u_host.cmd(OP_ENABLE);
        check("en", status, 8'h02);
        rd2(OP_STAT_RD, 13'h0000, b0, b1);
        check("status_read_cmd", b0, 8'h02);
        check("status_read_cmd", b1, 8'h02);
        u_host.cmd(OP_DISABLE);
        check("dis", status, 8'h00);
        u_host.stat_wr(8'h8C);
        settle();
        check("status_update_cmd", status, 8'h00);
        aw(13'h1FFF, 8'hA5, b0);
        check("aw", b0, 8'h01);
        u_host.cmd(OP_ENABLE);
        aw(13'h1FFF, 8'hA5, b0);
        check("aw", b0, 8'h02);
        check("busy", status, 8'h03);
        idle();
        check("done", status, 8'h00);
        u_host.cmd(OP_ENABLE);
        aw(13'h0000, 8'h3C, b0);
        rd2(OP_ARR_RD, 13'h0000, b0, b1);
        check("rdbusy", b0, 8'hFF);
        idle();
        rd2(OP_ARR_RD, 13'h1FFF, b0, b1);
        check("rd", b0, 8'hA5);
        check("rd", b1, 8'h3C);
        check("oe", {7'h00, oe_n}, 8'h01);
        rd2(8'h0A, 13'h0000, b0, b1);
        check("badop", b0, 8'hFF);
        set_wp(1'b0);
        u_host.cmd(OP_ENABLE);
        u_host.stat_wr(8'hFC);
        check("status_update_cmd", status, 8'h03);
        rd2(OP_STAT_RD, 13'h0000, b0, b1);
        check("status_read_cmd", b0, 8'h03);
        idle();
        check("status_update_cmd", status, 8'h8C);
        u_host.cmd(OP_ENABLE);
        u_host.stat_wr(8'h00);
        settle();
        check("hpm", status, 8'h8E);
        set_wp(1'b1);
        u_host.stat_wr(8'h00);
        idle();
        check("spm", status, 8'h00);
        u_host.cmd(OP_ENABLE);
        rd2(OP_STAT_WR, 13'h0000, b0, b1);
        settle();
        check("long", status, 8'h02);
        u_host.stat_wr(8'h04);
        idle();
        check("bg", status, 8'h04);
        u_host.cmd(OP_ENABLE);
        aw(13'h1800, 8'h11, b0);
        check("guard", b0, 8'h01);
        aw(13'h17FF, 8'h22, b0);
        check("free", b0, 8'h02);
        idle();
        aw(13'h0000, 8'h33, b0);
        check("nolat", b0, 8'h01);
        u_host.cmd(OP_ENABLE);
        check("en", status, 8'h06);
        // mid-run reset: the last captured frame must not re-commit
        @(negedge clock_in);
        rst_n_in = 1'b0;
        repeat (5) @(negedge clock_in);
        rst_n_in = 1'b1;
        settle();
        check("rst2", status, 8'h00);
        u_host.cmd(OP_ENABLE);
        check("en2", status, 8'h02);
        test_done();
    end
endmodule : spi_eeprom_status_and_read_tb

`default_nettype wire
